// ### rtl/ifs_pkg.sv
// Constants, carriers and lookup functions for the input filter and scaling block
// Operation
// - Repeating average sums readings, outputs sum/N each Nth reading, then clears both
// - Divisor N is the filter constant, default 10, executed every 1 ms tick
// - Low-pass sums four input and three output coefficient products, shifted by power
// - Seven coefficients sit in consecutive registers; a separate register holds the power
// - Low-pass runs every 10 ms and its output holds between runs
// - Filter output shifted by decimal count becomes the read-only field value
// - Type or range writes recompute the decimal count used by all field values
// - Decimal count per type: voltage 3, current 3, resistive 2, frequency 2/1/0, PWM 1
// - Field value is exported as the control signal for other blocks
// - Process points and decimal count default to the field points and count
// - Process value is a linear map of field value over the two point pairs
// - Field scale points only set the process value map; the exported field value is not bounded by them
// - Span limits and clear margin reload with type and range defaults
// - Voltage and current defaults load span, scale and margin per range
// - Resistive defaults are 2, 10, 20000, 25000 and 1
// - Frequency 100 Hz to 10 kHz defaults are 50, 100, 10000, 10500 and 10
// - Writes above max, span end above 110 percent or margin above 10 percent refused
// - Filter select 0 none, 1 unfiltered like 0, 2 repeating, 3 low-pass; default none
// - Sensor codes 40, 50, 60, 100, 10000 only; voltage is default
package ifs_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_1MS_NS   = 1000000;
  localparam int TICK_10MS_NS  = 10000000;
  localparam int TICK_1MS_CYC  = TICK_1MS_NS / CLK_PERIOD_NS;
  localparam int LP_TICKS      = TICK_10MS_NS / TICK_1MS_NS;

  localparam logic [15:0] AVG_DIV_RST  = 16'h000a;
  localparam logic [15:0] KIND_VOLT    = 16'h0028;
  localparam logic [15:0] KIND_CURR    = 16'h0032;
  localparam logic [15:0] KIND_FREQ    = 16'h003c;
  localparam logic [15:0] KIND_RES     = 16'h0064;
  localparam logic [15:0] KIND_PWM     = 16'h2710;
  localparam logic [15:0] RANGE_RST    = 16'h0000;
  localparam logic [15:0] FSEL_NONE    = 16'h0000;
  localparam logic [15:0] FSEL_REPEAT  = 16'h0002;
  localparam logic [15:0] FSEL_LOWPASS = 16'h0003;

  localparam logic [4:0] OFF_FSEL   = 5'h00;
  localparam logic [4:0] OFF_DIV    = 5'h01;
  localparam logic [4:0] OFF_KIND   = 5'h02;
  localparam logic [4:0] OFF_RANGE  = 5'h03;
  localparam logic [4:0] OFF_POW    = 5'h04;
  localparam logic [4:0] OFF_COEF0  = 5'h05;
  localparam logic [4:0] OFF_COEF6  = 5'h0b;
  localparam logic [4:0] OFF_FMIN   = 5'h0c;
  localparam logic [4:0] OFF_FMAX   = 5'h0d;
  localparam logic [4:0] OFF_PMIN   = 5'h0e;
  localparam logic [4:0] OFF_PMAX   = 5'h0f;
  localparam logic [4:0] OFF_PDC    = 5'h10;
  localparam logic [4:0] OFF_ELOW   = 5'h11;
  localparam logic [4:0] OFF_EHIGH  = 5'h12;
  localparam logic [4:0] OFF_MARGIN = 5'h13;
  localparam logic [4:0] OFF_FDC    = 5'h14;
  localparam logic [4:0] OFF_FIELD  = 5'h15;
  localparam logic [4:0] OFF_PROC   = 5'h16;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ifs_req_s;

  typedef struct packed {
    logic [1:0]  dd;
    logic [15:0] low;
    logic [15:0] smin;
    logic [15:0] smax;
    logic [15:0] high;
    logic [15:0] margin;
    logic [15:0] top;
  } ifs_dflt_s;

  function automatic ifs_dflt_s ifs_mk_f(input logic [1:0] dd, input logic [15:0] lo,
      input logic [15:0] mn, input logic [15:0] mx, input logic [15:0] hi,
      input logic [15:0] mg, input logic [15:0] tp);
    ifs_mk_f = '{dd: dd, low: lo, smin: mn, smax: mx, high: hi, margin: mg, top: tp};
  endfunction : ifs_mk_f

  // Defaults and range maximum per sensor kind and range
  function automatic ifs_dflt_s ifs_dflt_f(input logic [15:0] kind, input logic [15:0] rng);
    ifs_dflt_f = ifs_mk_f(2'h3, 16'h0032, 16'h0064, 16'h03e8, 16'h041a, 16'h0019, 16'h03e8);
    if (kind == KIND_VOLT && rng == 16'h0001)
      ifs_dflt_f = ifs_mk_f(2'h3, 16'h0064, 16'h00fa, 16'h09c4, 16'h0a28, 16'h0032, 16'h09c4);
    else if (kind == KIND_VOLT && rng == 16'h0002)
      ifs_dflt_f = ifs_mk_f(2'h3, 16'h00c8, 16'h01f4, 16'h1194, 16'h12c0, 16'h0064, 16'h1388);
    else if (kind == KIND_VOLT && rng == 16'h0003)
      ifs_dflt_f = ifs_mk_f(2'h3, 16'h00c8, 16'h01f4, 16'h251c, 16'h2648, 16'h00c8, 16'h2710);
    else if (kind == KIND_CURR && rng == 16'h0000)
      ifs_dflt_f = ifs_mk_f(2'h3, 16'h0000, 16'h0000, 16'h4e20, 16'h4e20, 16'h00fa, 16'h4e20);
    else if (kind == KIND_CURR)
      ifs_dflt_f = ifs_mk_f(2'h3, 16'h03e8, 16'h0fa0, 16'h4e20, 16'h5208, 16'h00fa, 16'h4e20);
    else if (kind == KIND_RES)
      ifs_dflt_f = ifs_mk_f(2'h2, 16'h0002, 16'h000a, 16'h4e20, 16'h61a8, 16'h0001, 16'h61a8);
    else if (kind == KIND_FREQ && rng == 16'h0000)
      ifs_dflt_f = ifs_mk_f(2'h2, 16'h0064, 16'h01f4, 16'h1388, 16'h157c, 16'h0014, 16'h1388);
    else if (kind == KIND_FREQ && rng == 16'h0001)
      ifs_dflt_f = ifs_mk_f(2'h1, 16'h0032, 16'h0064, 16'h2710, 16'h2af8, 16'h0032, 16'h2710);
    else if (kind == KIND_FREQ)
      ifs_dflt_f = ifs_mk_f(2'h0, 16'h0032, 16'h0064, 16'h2710, 16'h2904, 16'h000a, 16'h2710);
    else if (kind == KIND_PWM)
      ifs_dflt_f = ifs_mk_f(2'h1, 16'h000a, 16'h0032, 16'h03b6, 16'h03de, 16'h000a, 16'h03e8);
  endfunction : ifs_dflt_f

  function automatic logic ifs_kind_ok_f(input logic [15:0] kind);
    ifs_kind_ok_f = kind == KIND_VOLT || kind == KIND_CURR || kind == KIND_FREQ ||
                    kind == KIND_RES || kind == KIND_PWM;
  endfunction : ifs_kind_ok_f

  function automatic logic ifs_range_ok_f(input logic [15:0] kind, input logic [15:0] rng);
    ifs_range_ok_f = (kind == KIND_VOLT && rng < 16'h0004) ||
                     (kind == KIND_CURR && rng < 16'h0002) ||
                     (kind == KIND_FREQ && rng < 16'h0003) ||
                     (kind == KIND_RES && rng == 16'h0000) ||
                     (kind == KIND_PWM && rng < 16'h0002);
  endfunction : ifs_range_ok_f

  // Divisor from milli-unit samples to the decimal-digit scaled field value
  function automatic logic [15:0] ifs_scale_div_f(input logic [1:0] dd);
    case (dd)
      2'h3:    ifs_scale_div_f = 16'h0001;
      2'h2:    ifs_scale_div_f = 16'h000a;
      2'h1:    ifs_scale_div_f = 16'h0064;
      default: ifs_scale_div_f = 16'h03e8;
    endcase
  endfunction : ifs_scale_div_f

  localparam ifs_dflt_s DFLT_RST = ifs_dflt_f(KIND_VOLT, RANGE_RST);

endpackage : ifs_pkg

// ### rtl/ifs_input_filter.sv
// Input filter, decimal scaling and field-to-process mapping for one analog channel
//
// Decided for this implementation: the placing of the registers and strobed register access.
module ifs_input_filter
  import ifs_pkg::*;
#(
  parameter int TICK_CYC = TICK_1MS_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire ifs_req_s    req_i,
  input  wire logic [15:0] sample_i,
  input  wire logic        sample_valid_i,
  output logic      [15:0] rdata_o,
  output logic      [15:0] field_value_o,
  output logic      [15:0] process_value_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Ticks
  logic [31:0] tick_cnt_r;
  logic [3:0]  dec_cnt_r;
  logic        tick1_r;
  logic        tick10_r;
  wire logic   tick_wrap = tick_cnt_r == 32'(TICK_CYC - 1);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= 32'h0;
      dec_cnt_r  <= 4'h0;
      tick1_r    <= 1'b0;
      tick10_r   <= 1'b0;
    end else begin
      tick1_r    <= tick_wrap;
      tick10_r   <= tick_wrap && dec_cnt_r == 4'(LP_TICKS - 1);
      tick_cnt_r <= tick_wrap ? 32'h0 : tick_cnt_r + 32'h1;
      if (tick_wrap)
        dec_cnt_r <= (dec_cnt_r == 4'(LP_TICKS - 1)) ? 4'h0 : dec_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [15:0] fsel_r, div_r, kind_r, range_r, pow_r;
  logic [15:0] fmin_r, fmax_r, pmin_r, pmax_r, pdc_r;
  logic [15:0] elow_r, ehigh_r, margin_r;
  logic [1:0]  dd_r;
  logic [15:0] coef_r [7];
  wire logic        wr_fsel   = req_i.wr && req_i.addr == OFF_FSEL;
  wire logic        wr_div    = req_i.wr && req_i.addr == OFF_DIV;
  wire logic        wr_kind   = req_i.wr && req_i.addr == OFF_KIND;
  wire logic        wr_range  = req_i.wr && req_i.addr == OFF_RANGE;
  wire logic        wr_pow    = req_i.wr && req_i.addr == OFF_POW;
  wire logic        wr_coef   = req_i.wr && req_i.addr >= OFF_COEF0 && req_i.addr <= OFF_COEF6;
  wire logic [2:0]  coef_idx  = 3'(req_i.addr - OFF_COEF0);
  wire logic        wr_fmin   = req_i.wr && req_i.addr == OFF_FMIN;
  wire logic        wr_fmax   = req_i.wr && req_i.addr == OFF_FMAX;
  wire logic        wr_pmin   = req_i.wr && req_i.addr == OFF_PMIN;
  wire logic        wr_pmax   = req_i.wr && req_i.addr == OFF_PMAX;
  wire logic        wr_pdc    = req_i.wr && req_i.addr == OFF_PDC;
  wire logic        wr_elow   = req_i.wr && req_i.addr == OFF_ELOW;
  wire logic        wr_ehigh  = req_i.wr && req_i.addr == OFF_EHIGH;
  wire logic        wr_margin = req_i.wr && req_i.addr == OFF_MARGIN;

  wire logic        kind_ok   = ifs_kind_ok_f(req_i.wdata);
  wire logic        range_ok  = ifs_range_ok_f(kind_r, req_i.wdata);
  wire logic        reload    = (wr_kind && kind_ok) || (wr_range && range_ok);
  wire logic [15:0] kind_sel  = wr_kind ? req_i.wdata : kind_r;
  wire logic [15:0] range_sel = wr_kind ? RANGE_RST : req_i.wdata;
  wire ifs_dflt_s   dnew      = ifs_dflt_f(kind_sel, range_sel);
  wire ifs_dflt_s   dcur      = ifs_dflt_f(kind_r, range_r);
  wire logic [16:0] top17     = {1'b0, dcur.top};
  wire logic [16:0] high_lim  = top17 + top17 / 17'h0000a;
  wire logic [16:0] marg_lim  = top17 / 17'h0000a;
  wire logic [16:0] wdata17   = {1'b0, req_i.wdata};
  wire logic        fmax_ok   = wdata17 <= top17;
  wire logic        ehigh_ok  = wdata17 <= high_lim;
  wire logic        marg_ok   = wdata17 <= marg_lim;
  wire logic        fsel_ok   = req_i.wdata <= FSEL_LOWPASS;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fsel_r <= FSEL_NONE;
      div_r  <= AVG_DIV_RST;
      pow_r  <= 16'h0;
    end else begin
      if (wr_fsel && fsel_ok)
        fsel_r <= req_i.wdata;
      if (wr_div)
        div_r <= req_i.wdata;
      if (wr_pow)
        pow_r <= req_i.wdata;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 7; i++)
        coef_r[i] <= 16'h0;
    end else if (wr_coef) begin
      coef_r[coef_idx] <= req_i.wdata;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      kind_r   <= KIND_VOLT;
      range_r  <= RANGE_RST;
      dd_r     <= DFLT_RST.dd;
      elow_r   <= DFLT_RST.low;
      fmin_r   <= DFLT_RST.smin;
      fmax_r   <= DFLT_RST.smax;
      ehigh_r  <= DFLT_RST.high;
      margin_r <= DFLT_RST.margin;
      pmin_r   <= DFLT_RST.smin;
      pmax_r   <= DFLT_RST.smax;
      pdc_r    <= {14'h0, DFLT_RST.dd};
    end else if (reload) begin
      kind_r   <= kind_sel;
      range_r  <= range_sel;
      dd_r     <= dnew.dd;
      elow_r   <= dnew.low;
      fmin_r   <= dnew.smin;
      fmax_r   <= dnew.smax;
      ehigh_r  <= dnew.high;
      margin_r <= dnew.margin;
      pmin_r   <= dnew.smin;
      pmax_r   <= dnew.smax;
      pdc_r    <= {14'h0, dnew.dd};
    end else begin
      if (wr_fmin)
        fmin_r <= req_i.wdata;
      if (wr_fmax && fmax_ok)
        fmax_r <= req_i.wdata;
      if (wr_ehigh && ehigh_ok)
        ehigh_r <= req_i.wdata;
      if (wr_margin && marg_ok)
        margin_r <= req_i.wdata;
      if (wr_elow)
        elow_r <= req_i.wdata;
      if (wr_pmin)
        pmin_r <= req_i.wdata;
      if (wr_pmax)
        pmax_r <= req_i.wdata;
      if (wr_pdc)
        pdc_r <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filters
  logic [15:0] sample_r, filt_r;
  logic [31:0] acc_r;
  logic [15:0] cnt_r;
  logic [15:0] xh_r [3];
  logic [15:0] yh_r [3];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      sample_r <= 16'h0;
    else if (sample_valid_i)
      sample_r <= sample_i;
  end

  wire logic        avg_step = tick1_r && fsel_r == FSEL_REPEAT;
  wire logic [15:0] div_eff  = (div_r == 16'h0) ? 16'h0001 : div_r;
  wire logic [31:0] acc_nxt  = acc_r + {16'h0, sample_r};
  wire logic        avg_last = cnt_r + 16'h1 >= div_eff;
  wire logic [31:0] avg_quo  = acc_nxt / {16'h0, div_eff};
  wire logic [15:0] avg_q    = avg_quo[15:0];
  wire logic        lp_step  = tick10_r && fsel_r == FSEL_LOWPASS;

  logic signed [15:0] tap [7];
  logic signed [32:0] prod [7];
  assign tap[0] = signed'(sample_r);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_taps
      assign tap[g + 1] = signed'(xh_r[g]);
      assign tap[g + 4] = signed'(yh_r[g]);
    end
    for (g = 0; g < 7; g++) begin : g_prod
      assign prod[g] = 33'(signed'(coef_r[g]) * tap[g]);
    end
  endgenerate

  wire logic signed [35:0] lp_sum = 36'(prod[0]) + 36'(prod[1]) + 36'(prod[2]) +
                                     36'(prod[3]) + 36'(prod[4]) + 36'(prod[5]) +
                                     36'(prod[6]);
  wire logic signed [35:0] lp_shf = lp_sum >>> pow_r[5:0];
  wire logic        [15:0] lp_res = lp_shf[15:0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= 32'h0;
      cnt_r <= 16'h0;
    end else if (avg_step && avg_last) begin
      acc_r <= 32'h0;
      cnt_r <= 16'h0;
    end else if (avg_step) begin
      acc_r <= acc_nxt;
      cnt_r <= cnt_r + 16'h1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        xh_r[i] <= 16'h0;
        yh_r[i] <= 16'h0;
      end
    end else if (lp_step) begin
      xh_r[0] <= sample_r;
      yh_r[0] <= lp_res;
      for (int i = 1; i < 3; i++) begin
        xh_r[i] <= xh_r[i - 1];
        yh_r[i] <= yh_r[i - 1];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      filt_r <= 16'h0;
    else if (avg_step && avg_last)
      filt_r <= avg_q;
    else if (lp_step)
      filt_r <= lp_res;
    else if (tick1_r && fsel_r != FSEL_REPEAT && fsel_r != FSEL_LOWPASS)
      filt_r <= sample_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field and process values
  logic [15:0] field_r, proc_r, rdata_r;
  wire logic [15:0]        field_nxt = filt_r / ifs_scale_div_f(dd_r);
  wire logic signed [17:0] num_d     = 18'(signed'({2'b0, field_r}) - signed'({2'b0, fmin_r}));
  wire logic signed [17:0] pspan     = 18'(signed'({2'b0, pmax_r}) - signed'({2'b0, pmin_r}));
  wire logic signed [17:0] fspan     = 18'(signed'({2'b0, fmax_r}) - signed'({2'b0, fmin_r}));
  wire logic signed [35:0] map_prod  = num_d * pspan;
  wire logic signed [35:0] map_quo   = (fspan == 18'sh0) ? 36'sh0 : map_prod / 36'(fspan);
  wire logic signed [35:0] map_sum   = map_quo + 36'(signed'({2'b0, pmin_r}));
  wire logic [15:0]        proc_nxt  = map_sum[15:0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      field_r <= 16'h0;
      proc_r  <= 16'h0;
    end else begin
      field_r <= field_nxt;
      proc_r  <= proc_nxt;
    end
  end

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0;
    if (req_i.addr == OFF_FSEL)
      rd_mux = fsel_r;
    else if (req_i.addr == OFF_DIV)
      rd_mux = div_r;
    else if (req_i.addr == OFF_KIND)
      rd_mux = kind_r;
    else if (req_i.addr == OFF_RANGE)
      rd_mux = range_r;
    else if (req_i.addr == OFF_POW)
      rd_mux = pow_r;
    else if (req_i.addr >= OFF_COEF0 && req_i.addr <= OFF_COEF6)
      rd_mux = coef_r[coef_idx];
    else if (req_i.addr == OFF_FMIN)
      rd_mux = fmin_r;
    else if (req_i.addr == OFF_FMAX)
      rd_mux = fmax_r;
    else if (req_i.addr == OFF_PMIN)
      rd_mux = pmin_r;
    else if (req_i.addr == OFF_PMAX)
      rd_mux = pmax_r;
    else if (req_i.addr == OFF_PDC)
      rd_mux = pdc_r;
    else if (req_i.addr == OFF_ELOW)
      rd_mux = elow_r;
    else if (req_i.addr == OFF_EHIGH)
      rd_mux = ehigh_r;
    else if (req_i.addr == OFF_MARGIN)
      rd_mux = margin_r;
    else if (req_i.addr == OFF_FDC)
      rd_mux = {14'h0, dd_r};
    else if (req_i.addr == OFF_FIELD)
      rd_mux = field_r;
    else if (req_i.addr == OFF_PROC)
      rd_mux = proc_r;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      rdata_r <= 16'h0;
    else if (req_i.rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 16'h0;
  end

  assign rdata_o         = rdata_r;
  assign field_value_o   = field_r;
  assign process_value_o = proc_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_avg_close;
    avg_step && avg_last;
  endsequence
  sequence s_avg_cleared;
    acc_r == 32'h0 && cnt_r == 16'h0;
  endsequence

  a_avg_result: assert property (s_avg_close |=> filt_r == $past(avg_q) ##0 s_avg_cleared)
    else $error("repeating average result or clear wrong");
  a_avg_count: assert property ((avg_step && !avg_last) |=> cnt_r == $past(cnt_r) + 16'h1)
    else $error("repeating average counter did not advance");
  a_lp_period: assert property (tick10_r |-> tick1_r && $past(dec_cnt_r) == 4'(LP_TICKS - 1))
    else $error("low-pass tick off its 10 ms slot");
  a_lp_hold: assert property ((fsel_r == FSEL_LOWPASS && !lp_step) |=> $stable(filt_r))
    else $error("low-pass output changed between runs");
  a_field_shift: assert property (##1 field_r == $past(filt_r) / ifs_scale_div_f($past(dd_r)))
    else $error("field value not scaled by decimal count");
  a_dd_reload: assert property (reload |=> dd_r == $past(dnew.dd) && elow_r == $past(dnew.low))
    else $error("decimal count or span not reloaded");
  a_pv_default: assert property (reload |=> pmin_r == fmin_r && pmax_r == fmax_r
    && pdc_r[1:0] == dd_r) else $error("process points not defaulted to field points");
  a_max_reject: assert property ((wr_fmax && !fmax_ok && !reload) |=> $stable(fmax_r))
    else $error("scale max above range accepted");
  a_kind_reject: assert property ((wr_kind && !kind_ok) |=> $stable(kind_r))
    else $error("illegal sensor code accepted");

endmodule : ifs_input_filter

// ### sim/ifs_sample_src.sv
// Behavioural front end that hands raw readings to the filter block
module ifs_sample_src (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] value_i,
  input  wire logic        slow_i,
  output logic      [15:0] sample_o,
  output logic             valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_r;
  // Slow mode offers a reading every third cycle only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) gap_r <= 2'h0;
    else gap_r <= (gap_r == 2'h2) ? 2'h0 : gap_r + 2'h1;
  end
  assign valid_o  = !rst_i && (!slow_i || gap_r == 2'h0);
  // Outside a valid cycle the bus shows junk, never the last reading
  assign sample_o = valid_o ? value_i : ~value_i;
endmodule : ifs_sample_src

// ### sim/tb_top.sv
// Self-checking bench for the input filter and scaling block
module tb_top
  import ifs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 20;
  logic core_clk_i, rst_i, slow, rd_q;
  ifs_req_s req;
  logic [15:0] val, sample, rdata, fv, pv;
  logic valid;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  logic [15:0] tab[6][8];
  int errors, n_tests;
  ifs_input_filter #(.TICK_CYC(TK)) u_ifs_input_filter (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .req_i(req), .sample_i(sample), .sample_valid_i(valid), .rdata_o(rdata),
    .field_value_o(fv), .process_value_o(pv));
  ifs_sample_src u_ifs_sample_src (.core_clk_i(core_clk_i), .rst_i(rst_i), .value_i(val),
    .slow_i(slow), .sample_o(sample), .valid_o(valid));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] lfsr_f(input logic [31:0] x);
    lfsr_f = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_f
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic bus(input logic [4:0] a, input logic [15:0] d, input logic w, input logic r);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(a, 16'h0000, 1'b0, 1'b1);
  endtask : rd
  task automatic idle(input int n);
    bus(5'h00, 16'h0000, 1'b0, 1'b0);
    repeat (n) @(posedge core_clk_i);
  endtask : idle
  // Read data stands only in the cycle after the read strobe
  always @(posedge core_clk_i) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("Error at %0t: got %h expected nothing", $time, rdata);
      end else chk(rdata, exp_q.pop_front());
    end
    rd_q <= req.rd;
  end
  initial begin
    repeat (100000) @(posedge core_clk_i);
    errors++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  end
  initial begin
    rst_i = 1'b1;
    req = '0;
    val = 16'h0000;
    slow = 1'b0;
    seed = 32'h3773c499;
    errors = 0;
    n_tests = 0;
    // Kind, range, dd, span low, scale min, scale max, span high, margin
    tab = '{'{16'h0032, 16'h0001, 16'h0003, 16'h03e8, 16'h0fa0, 16'h4e20, 16'h5208, 16'h00fa},
            '{16'h0064, 16'h0000, 16'h0002, 16'h0002, 16'h000a, 16'h4e20, 16'h61a8, 16'h0001},
            '{16'h003c, 16'h0002, 16'h0000, 16'h0032, 16'h0064, 16'h2710, 16'h2904, 16'h000a},
            '{16'h003c, 16'h0000, 16'h0002, 16'h0064, 16'h01f4, 16'h1388, 16'h157c, 16'h0014},
            '{16'h2710, 16'h0000, 16'h0001, 16'h000a, 16'h0032, 16'h03b6, 16'h03de, 16'h000a},
            '{16'h0028, 16'h0003, 16'h0003, 16'h00c8, 16'h01f4, 16'h251c, 16'h2648, 16'h00c8}};
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(OFF_FSEL, 16'h0000);
    rd(OFF_DIV, 16'h000a);
    rd(OFF_KIND, 16'h0028);
    rd(OFF_FDC, 16'h0003);
    rd(OFF_PDC, 16'h0003);
    rd(5'h1f, 16'h0000);
    idle(3);
    $display("Reset values done");
    foreach (tab[i]) begin
      wr(OFF_KIND, tab[i][0]);
      wr(OFF_RANGE, tab[i][1]);
      rd(OFF_FDC, tab[i][2]);
      rd(OFF_ELOW, tab[i][3]);
      rd(OFF_FMIN, tab[i][4]);
      rd(OFF_FMAX, tab[i][5]);
      rd(OFF_EHIGH, tab[i][6]);
      rd(OFF_MARGIN, tab[i][7]);
      rd(OFF_PMIN, tab[i][4]);
      rd(OFF_PMAX, tab[i][5]);
      rd(OFF_PDC, tab[i][2]);
    end
    wr(OFF_KIND, 16'h0029);
    wr(OFF_RANGE, 16'h0004);
    wr(OFF_FDC, 16'h0000);
    rd(OFF_KIND, 16'h0028);
    rd(OFF_RANGE, 16'h0003);
    rd(OFF_FDC, 16'h0003);
    idle(3);
    $display("Type and range defaults done");
    wr(OFF_FMAX, 16'h2711);
    wr(OFF_EHIGH, 16'h2af9);
    wr(OFF_MARGIN, 16'h03e9);
    rd(OFF_FMAX, 16'h251c);
    rd(OFF_EHIGH, 16'h2648);
    rd(OFF_MARGIN, 16'h00c8);
    wr(OFF_FMAX, 16'h2710);
    wr(OFF_EHIGH, 16'h2af8);
    wr(OFF_MARGIN, 16'h03e8);
    rd(OFF_FMAX, 16'h2710);
    rd(OFF_EHIGH, 16'h2af8);
    rd(OFF_MARGIN, 16'h03e8);
    wr(OFF_RANGE, 16'h0003);
    idle(3);
    $display("Limit checks done");
    wr(OFF_FSEL, 16'h0001);
    wr(OFF_FSEL, 16'h0004);
    rd(OFF_FSEL, 16'h0001);
    seed = lfsr_f(seed);
    val <= seed[15:0] & 16'h1fff;
    idle(3 * TK);
    chk(fv, val);
    chk(pv, val);
    rd(OFF_FIELD, val);
    wr(OFF_PMIN, 16'h0000);
    wr(OFF_PMAX, 16'h07d0);
    val <= 16'h1388;
    idle(3 * TK);
    chk(pv, 16'h03e8);
    chk(fv, 16'h1388);
    $display("Scaling done");
    seed = lfsr_f(seed);
    slow <= 1'b1;
    val <= seed[15:0] & 16'h1fff;
    wr(OFF_DIV, 16'h0004);
    wr(OFF_FSEL, FSEL_REPEAT);
    idle(10 * TK);
    chk(fv, val);
    wr(OFF_POW, 16'h0001);
    wr(OFF_COEF0, 16'h0003);
    wr(OFF_FSEL, FSEL_LOWPASS);
    idle(12 * LP_TICKS * TK);
    chk(fv, 16'((val * 3) >> 1));
    rd(OFF_FIELD, 16'((val * 3) >> 1));
    idle(3);
    $display("Filters done");
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rd(OFF_FSEL, FSEL_NONE);
    rd(OFF_FIELD, 16'h0000);
    idle(3);
    $display("Mid-run reset done");
    finish_test();
  end
endmodule : tb_top
